// [cmt_pkg.sv]
/*
  Shared constants and types of the CAN message and bit timing engine:
  register offsets, field positions, reset values, cycle costs, frame
  layout and buffer states.
  Assumes a single 100 MHz system clock and word-only register access.
*/
package cmt_pkg;

  // ****************************************
  // Clock and cycle costs
  // ****************************************
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned COPY_CYC     = 17;
  localparam int unsigned UPDATE_CYC   = 3;
  localparam int unsigned SCHED_CYC    = 2;
  localparam int unsigned OBJ_WAIT_CYC = 2;

  // ****************************************
  // Simplified frame layout, bit numbers
  // ****************************************
  localparam logic [5:0] HDR_FIRST_BIT = 6'h01;
  localparam logic [5:0] DATA_LAST_BIT = 6'h30;
  localparam logic [5:0] VALID_BIT     = 6'h36;
  localparam logic [5:0] LAST_BIT      = 6'h3a;
  localparam int unsigned REMOTE_BIT   = 0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] TIM_OFS    = 12'h004;
  localparam logic [11:0] GMASK_OFS  = 12'h008;
  localparam logic [11:0] BMASK_OFS  = 12'h00c;
  localparam logic [11:0] STATUS_OFS = 12'h010;
  localparam logic [11:0] BUF_BASE   = 12'h100;
  localparam logic [7:0]  BUF_IDX0   = 8'h10;
  localparam logic [3:0]  BUF_HDR    = 4'h0;
  localparam logic [3:0]  BUF_DATA   = 4'h4;
  localparam logic [3:0]  BUF_STATE  = 4'h8;

  // ****************************************
  // Field positions and offsets
  // ****************************************
  localparam int unsigned TIM_PRESC_LSB = 0;
  localparam int unsigned TIM_SEGA_LSB = 8;
  localparam int unsigned TIM_SEGB_LSB = 12;
  localparam logic [6:0]  PRESC_ADD    = 7'h02;
  localparam logic [4:0]  SEGA_ADD     = 5'h01;
  localparam logic [3:0]  SEGB_ADD     = 4'h1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] GMASK_RST = 32'h0000_0001;
  localparam logic [31:0] BMASK_RST = 32'h0000_0001;
  localparam logic        PIN_IDLE  = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    buf_rx_empty, buf_rx_full, buf_tx_idle, buf_tx_send,
    buf_reply_pending, buf_reply_single
  } cmt_buf_state_type;

  typedef struct packed {
    logic [31:0]       hdr;
    logic [15:0]       data;
    cmt_buf_state_type st;
  } cmt_msg_buf_type;

  typedef struct packed {
    logic [5:0] bit_prescaler;
    logic [3:0] seg_a;
    logic [2:0] seg_b;
  } cmt_timing_type;

endpackage

// [cmt_can_engine.sv]
/*
  CAN message processing and bit timing engine with an AHB-Lite slave.
  Assumes an external transceiver on the bus pins and one system clock.
*/
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
// Overview of operation
// - Hidden-to-receive copy costs 17 cycles, once
// - Pending-to-single reply update costs 3 cycles each
// - Scheduling next transmission costs 2 cycles, once
// - Processing done before next frame may start; code holds back only its own transmission start, not a reception
// - Update count follows number of matching buffers
// - Message object accesses add bus wait cycles
// - Bit is sync plus segments, quantum is prescaler
// - Prescaler field plus 2, segments plus 1
// - Masks filter all 32 header bits
// - Remote frame answered with remote bit cleared
// - Sent remote frame turns buffer to receive
// - Own frame copied after same-identifier reception
// - Different identifier in between prevents self copy
// - Drive transmit pin, sample receive pin
module cmt_can_engine
  import cmt_pkg::*;
#(
  parameter int unsigned NUM_BUF  = 15,
  parameter int unsigned OBJ_WAIT = OBJ_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Bus pins
  input  wire logic        bus_rx_pin,
  output logic             bus_tx_pin
);

  localparam int unsigned IW = $clog2(NUM_BUF);

  typedef enum logic [1:0] {ph_sync, ph_a, ph_b} cmt_phase_type;
  typedef enum logic {fr_idle, fr_bits} cmt_frame_type;
  typedef enum logic [1:0] {pr_idle, pr_copy, pr_upd, pr_sched} cmt_proc_type;

  typedef struct packed {
    logic [2:0]                    rx_sync;
    logic                          rx_level;
    logic [6:0]                    tq_cnt;
    logic [3:0]                    seg_cnt;
    cmt_phase_type                 phase;
    cmt_frame_type                 fr;
    logic [5:0]                    bit_cnt;
    logic [47:0]                   rx_shift;
    logic                          tx_active;
    logic [IW-1:0]                 tx_idx;
    logic [47:0]                   tx_word;
    logic                          tx_pin;
    cmt_proc_type                  pr;
    logic [4:0]                    pr_cnt;
    logic [31:0]                   pr_hdr;
    logic [15:0]                   pr_data;
    logic                          pr_self;
    logic                          sched_valid;
    logic [IW-1:0]                 sched_idx;
    logic [31:0]                   last_hdr;
    logic                          last_valid;
    logic                          enable;
    cmt_timing_type                tim;
    logic [31:0]                   gmask;
    logic [31:0]                   bmask;
    cmt_msg_buf_type [NUM_BUF-1:0] bufs;
    logic                          dp_valid;
    logic                          dp_write;
    logic [11:0]                   dp_addr;
    logic [3:0]                    wait_cnt;
    logic                          hready_r;
    logic [31:0]                   hrdata_r;
  } cmt_state_type;

  cmt_state_type st_r;
  cmt_state_type st_nxt;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic hdr_match(input logic [31:0] a, input logic [31:0] b,
                                     input logic [31:0] m);
    return ((a ^ b) & ~m) == 32'h0000_0000;
  endfunction

  function automatic logic [IW-1:0] lowest(input logic [NUM_BUF-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = i[IW-1:0];
      end
    end
    return idx;
  endfunction

  // Last buffer filters through the basic mask, the rest the global one
  function automatic logic [NUM_BUF-1:0] match_vec(input cmt_state_type s,
                                                   input logic [31:0] hdr,
                                                   input cmt_buf_state_type want);
    logic [NUM_BUF-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      v[i] = (s.bufs[i].st == want) &&
             hdr_match(hdr, s.bufs[i].hdr, (i == NUM_BUF - 1) ? s.bmask : s.gmask);
    end
    return v;
  endfunction

  function automatic logic [NUM_BUF-1:0] tx_vec(input cmt_state_type s);
    logic [NUM_BUF-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      v[i] = (s.bufs[i].st == buf_tx_send) || (s.bufs[i].st == buf_reply_single);
    end
    return v;
  endfunction

  function automatic logic [31:0] rd_word(input cmt_state_type s, input logic [11:0] a);
    logic [31:0] d;
    logic [7:0]  bi;
    d  = 32'h0000_0000;
    bi = a[11:4] - BUF_IDX0;
    case (a)
      CTRL_OFS:   d = {31'h0000_0000, s.enable};
      TIM_OFS:    d = {17'h0_0000, s.tim.seg_b, s.tim.seg_a, 2'b00, s.tim.bit_prescaler};
      GMASK_OFS:  d = s.gmask;
      BMASK_OFS:  d = s.bmask;
      STATUS_OFS: d = 32'({s.rx_level, s.sched_idx, s.sched_valid, s.tx_active,
                           s.pr != pr_idle, s.fr != fr_idle});
      default: begin
        if (a >= BUF_BASE && 32'(bi) < NUM_BUF) begin
          case (a[3:0])
            BUF_HDR:   d = s.bufs[bi[IW-1:0]].hdr;
            BUF_DATA:  d = {16'h0000, s.bufs[bi[IW-1:0]].data};
            BUF_STATE: d = {29'h0000_0000, s.bufs[bi[IW-1:0]].st};
            default:   d = 32'h0000_0000;
          endcase
        end
      end
    endcase
    return d;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [6:0]         pre_eff;
    logic [4:0]         sega_eff;
    logic [3:0]         segb_eff;
    logic               tick;
    logic               sample_pt;
    logic               bit_end;
    logic               fell;
    logic               validate;
    logic [31:0]        hdr;
    logic               quirk;
    logic [NUM_BUF-1:0] cv;
    logic [NUM_BUF-1:0] uv;
    logic [NUM_BUF-1:0] tv;
    logic [7:0]         bi;
    logic [11:0]        wa;
    st_nxt   = st_r;
    pre_eff  = {1'b0, st_r.tim.bit_prescaler} + PRESC_ADD;
    sega_eff = {1'b0, st_r.tim.seg_a} + SEGA_ADD;
    segb_eff = {1'b0, st_r.tim.seg_b} + SEGB_ADD;
    validate = 1'b0;
    tick      = 1'b0;
    sample_pt = 1'b0;
    bit_end   = 1'b0;
    fell      = 1'b0;
    hdr      = st_r.rx_shift[47:16];
    quirk    = 1'b0;
    cv       = '0;
    uv       = '0;
    tv       = tx_vec(st_r);
    wa       = st_r.dp_addr;
    bi       = wa[11:4] - BUF_IDX0;

    // Three stage pin filter, level taken once stages two and three agree
    st_nxt.rx_sync = {st_r.rx_sync[1:0], bus_rx_pin};
    if (st_r.rx_sync[1] == st_r.rx_sync[2]) begin
      st_nxt.rx_level = st_r.rx_sync[2];
    end
    fell = st_r.rx_level && !st_nxt.rx_level;

    // Quantum is pre_eff clocks; bit is sync plus two segments
    tick      = st_r.tq_cnt == pre_eff - 7'h01;
    sample_pt = tick && st_r.phase == ph_a && {1'b0, st_r.seg_cnt} == sega_eff - 5'h01;
    bit_end   = tick && st_r.phase == ph_b && st_r.seg_cnt == segb_eff - 4'h1;
    if (tick) begin
      st_nxt.tq_cnt = 7'h00;
      case (st_r.phase)
        ph_sync: begin
          st_nxt.phase   = ph_a;
          st_nxt.seg_cnt = 4'h0;
        end
        ph_a: begin
          st_nxt.phase   = sample_pt ? ph_b : ph_a;
          st_nxt.seg_cnt = sample_pt ? 4'h0 : st_r.seg_cnt + 4'h1;
        end
        ph_b: begin
          st_nxt.phase   = bit_end ? ph_sync : ph_b;
          st_nxt.seg_cnt = bit_end ? 4'h0 : st_r.seg_cnt + 4'h1;
        end
        default: st_nxt.phase = ph_sync;
      endcase
    end else begin
      st_nxt.tq_cnt = st_r.tq_cnt + 7'h01;
    end
    // Only hard sync on idle falling edge; no resync jump inside a frame
    if (!st_r.enable || (st_r.fr == fr_idle && fell)) begin
      st_nxt.tq_cnt  = 7'h00;
      st_nxt.seg_cnt = 4'h0;
      st_nxt.phase   = st_r.enable ? ph_a : ph_sync;
    end

    // ****************************************
    // Frame engine
    // ****************************************
    case (st_r.fr)
      fr_idle: begin
        if (st_r.enable && sample_pt && !st_r.rx_level) begin
          st_nxt.fr        = fr_bits;
          st_nxt.bit_cnt   = HDR_FIRST_BIT;
          st_nxt.tx_active = 1'b0;
        end else if (st_r.enable && bit_end && st_r.sched_valid
                     && st_r.pr == pr_idle) begin
          st_nxt.fr          = fr_bits;
          st_nxt.bit_cnt     = 6'h00;
          st_nxt.tx_active   = 1'b1;
          st_nxt.tx_idx      = st_r.sched_idx;
          st_nxt.sched_valid = 1'b0;
          st_nxt.tx_word     = {st_r.bufs[st_r.sched_idx].hdr, st_r.bufs[st_r.sched_idx].data};
          if (st_r.bufs[st_r.sched_idx].st == buf_reply_single) begin
            st_nxt.tx_word[16 + REMOTE_BIT] = 1'b0;
          end
          st_nxt.tx_pin = 1'b0;
        end
      end
      fr_bits: begin
        if (bit_end) begin
          st_nxt.tx_pin = PIN_IDLE;
          if (st_r.tx_active && st_r.bit_cnt >= HDR_FIRST_BIT
              && st_r.bit_cnt <= DATA_LAST_BIT) begin
            st_nxt.tx_pin = st_r.tx_word[DATA_LAST_BIT - st_r.bit_cnt];
          end
        end
        if (sample_pt) begin
          st_nxt.bit_cnt = st_r.bit_cnt + 6'h01;
          if (st_r.bit_cnt >= HDR_FIRST_BIT && st_r.bit_cnt <= DATA_LAST_BIT) begin
            st_nxt.rx_shift = {st_r.rx_shift[46:0], st_r.rx_level};
            // Recessive sent but dominant seen: arbitration lost
            if (st_r.tx_active && st_r.tx_pin && !st_r.rx_level) begin
              st_nxt.tx_active = 1'b0;
              st_nxt.tx_pin    = PIN_IDLE;
            end
          end
          validate = st_r.bit_cnt == VALID_BIT;
          if (st_r.bit_cnt == LAST_BIT) begin
            st_nxt.fr        = fr_idle;
            st_nxt.tx_active = 1'b0;
            st_nxt.tx_pin    = PIN_IDLE;
          end
        end
        if (!st_r.enable) begin
          st_nxt.fr        = fr_idle;
          st_nxt.tx_active = 1'b0;
          st_nxt.tx_pin    = PIN_IDLE;
        end
      end
      default: st_nxt.fr = fr_idle;
    endcase

    // ****************************************
    // Register writes, data phase end
    // ****************************************
    if (st_r.dp_valid && st_r.hready_r && st_r.dp_write) begin
      case (wa)
        CTRL_OFS: st_nxt.enable = hwdata[0];
        TIM_OFS: begin
          st_nxt.tim.bit_prescaler = hwdata[TIM_PRESC_LSB +: 6];
          st_nxt.tim.seg_a = hwdata[TIM_SEGA_LSB +: 4];
          st_nxt.tim.seg_b = hwdata[TIM_SEGB_LSB +: 3];
        end
        GMASK_OFS: st_nxt.gmask = hwdata;
        BMASK_OFS: st_nxt.bmask = hwdata;
        default: begin
          if (wa >= BUF_BASE && 32'(bi) < NUM_BUF) begin
            case (wa[3:0])
              BUF_HDR:   st_nxt.bufs[bi[IW-1:0]].hdr  = hwdata;
              BUF_DATA:  st_nxt.bufs[bi[IW-1:0]].data = hwdata[15:0];
              BUF_STATE: st_nxt.bufs[bi[IW-1:0]].st   = cmt_buf_state_type'(hwdata[2:0]);
              default:   st_nxt.bufs[bi[IW-1:0]].st   = st_r.bufs[bi[IW-1:0]].st;
            endcase
          end
        end
      endcase
    end

    // ****************************************
    // Post-reception processing
    // ****************************************
    case (st_r.pr)
      pr_idle: begin
        if (!st_r.sched_valid && |tv && !st_r.tx_active) begin
          st_nxt.pr     = pr_sched;
          st_nxt.pr_cnt = 5'h00;
        end
      end
      pr_copy: begin
        st_nxt.pr_cnt = st_r.pr_cnt + 5'h01;
        if (st_r.pr_cnt == 5'(COPY_CYC - 1)) begin
          cv = match_vec(st_r, st_r.pr_hdr, buf_rx_empty);
          if (|cv) begin
            st_nxt.bufs[lowest(cv)].hdr  = st_r.pr_hdr;
            st_nxt.bufs[lowest(cv)].data = st_r.pr_data;
            st_nxt.bufs[lowest(cv)].st   = buf_rx_full;
          end
          st_nxt.pr     = pr_upd;
          st_nxt.pr_cnt = 5'h00;
        end
      end
      pr_upd: begin
        if (!st_r.pr_self && st_r.pr_hdr[REMOTE_BIT]) begin
          uv = match_vec(st_r, st_r.pr_hdr, buf_reply_pending);
        end
        st_nxt.pr_cnt = st_r.pr_cnt + 5'h01;
        if (uv == '0) begin
          st_nxt.pr     = pr_sched;
          st_nxt.pr_cnt = 5'h00;
        end else if (st_r.pr_cnt == 5'(UPDATE_CYC - 1)) begin
          st_nxt.bufs[lowest(uv)].st = buf_reply_single;
          st_nxt.pr_cnt = 5'h00;
        end
      end
      pr_sched: begin
        st_nxt.pr_cnt = st_r.pr_cnt + 5'h01;
        if (st_r.pr_cnt == 5'(SCHED_CYC - 1)) begin
          if (|tv && !st_r.sched_valid) begin
            st_nxt.sched_valid = 1'b1;
            st_nxt.sched_idx   = lowest(tv);
          end
          st_nxt.pr = pr_idle;
        end
      end
      default: st_nxt.pr = pr_idle;
    endcase

    // Validation point: bookkeeping and start of processing
    if (validate) begin
      quirk = st_r.tx_active && st_r.last_valid && hdr == st_r.last_hdr;
      cv    = match_vec(st_r, hdr, buf_rx_empty);
      if (st_r.tx_active) begin
        st_nxt.bufs[st_r.tx_idx].st = st_r.tx_word[16 + REMOTE_BIT] ? buf_rx_empty
                                                                     : buf_tx_idle;
        if (hdr != st_r.last_hdr) begin
          st_nxt.last_valid = 1'b0;
        end
      end else begin
        st_nxt.last_hdr   = hdr;
        st_nxt.last_valid = 1'b1;
      end
      st_nxt.pr_hdr  = hdr;
      st_nxt.pr_data = st_r.rx_shift[15:0];
      st_nxt.pr_self = st_r.tx_active;
      st_nxt.pr_cnt  = 5'h00;
      st_nxt.pr      = ((!st_r.tx_active || quirk) && |cv) ? pr_copy : pr_upd;
    end

    // ****************************************
    // AHB-Lite slave phases
    // ****************************************
    if (st_r.dp_valid && !st_r.hready_r) begin
      st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
      if (st_r.wait_cnt == 4'h1) begin
        st_nxt.hready_r = 1'b1;
        st_nxt.hrdata_r = st_r.dp_write ? 32'h0000_0000 : rd_word(st_r, st_r.dp_addr);
      end
    end
    if (st_r.dp_valid && st_r.hready_r) begin
      st_nxt.dp_valid = 1'b0;
    end
    // Zero-wait reads see state before a write ending in the same cycle
    if (hsel && htrans[1] && hready) begin
      st_nxt.dp_valid = 1'b1;
      st_nxt.dp_write = hwrite;
      st_nxt.dp_addr  = haddr[11:0];
      st_nxt.hrdata_r = hwrite ? 32'h0000_0000 : rd_word(st_r, haddr[11:0]);
      st_nxt.hready_r = 1'b1;
      if (haddr[11:0] >= BUF_BASE && OBJ_WAIT > 0) begin
        st_nxt.hready_r = 1'b0;
        st_nxt.wait_cnt = 4'(OBJ_WAIT);
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r          <= '0;
      st_r.rx_sync  <= 3'h7;
      st_r.rx_level <= PIN_IDLE;
      st_r.tx_pin   <= PIN_IDLE;
      st_r.gmask    <= GMASK_RST;
      st_r.bmask    <= BMASK_RST;
      st_r.hready_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata     = st_r.hrdata_r;
  assign hreadyout  = st_r.hready_r;
  assign hresp      = 1'b0;
  assign bus_tx_pin = st_r.tx_pin;

endmodule

// [cmt_can_engine_properties.sv]
/*
  Checker of bus answers and pin timing of cmt_can_engine.
  Assumes bit timing never shorter than 8 clocks and word-only access.
*/
module cmt_can_engine_props
  import cmt_pkg::*;
#(
  parameter int unsigned OBJ_WAIT = OBJ_WAIT_CYC
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // AHB-Lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Bus pins
  input wire logic        bus_rx_pin,
  input wire logic        bus_tx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Helpers
  // ****************************************
  logic [3:0] wcnt_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Counts stall cycles of one object access
  always_ff @(posedge clk_sys) begin
    if (rst || hreadyout) wcnt_r <= 4'h0;
    else wcnt_r <= wcnt_r + 4'h1;
  end
  sequence s_obj_req;
    hsel && htrans[1] && hready && haddr[11:8] != 4'h0;
  endsequence
  sequence s_reg_req;
    hsel && htrans[1] && hready && haddr[11:8] == 4'h0;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_reset_idle: assert property ($fell(rst) |-> bus_tx_pin && hreadyout
    && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_reg_nowait: assert property (s_reg_req |=> hreadyout)
    else $error("register access stalled");
  a_obj_stall: assert property (s_obj_req |=> !hreadyout)
    else $error("object access not stalled");
  a_wait_length: assert property ($rose(hreadyout) |-> 32'(wcnt_r) == OBJ_WAIT)
    else $error("object wait length wrong");
  a_wait_bound: assert property (!hreadyout |-> 32'(wcnt_r) < OBJ_WAIT)
    else $error("object wait too long");
  a_stall_cause: assert property ($fell(hreadyout) |->
    $past(haddr[11:8]) != 4'h0 && $past(hsel))
    else $error("stall without object access");
  a_write_zero: assert property (s_reg_req ##0 hwrite |=> hrdata == 32'h0)
    else $error("read data not zero on write");
  a_unmapped_zero: assert property (s_reg_req ##0 (!hwrite && haddr[11:0] > STATUS_OFS)
    |=> hrdata == 32'h0)
    else $error("unmapped offset read not zero");
  a_tx_hold: assert property ($changed(bus_tx_pin) |=> $stable(bus_tx_pin) [*7])
    else $error("transmit level shorter than minimum bit");
endmodule
bind cmt_can_engine cmt_can_engine_props #(.OBJ_WAIT(OBJ_WAIT)) cmt_can_engine_props_i (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin));

// [cmt_bus_node.sv]
/*
  Behavioural far node on the CAN bus with the transceiver folded in.
  Assumes the engine's simplified frame and a fixed bit length in clocks.
*/
module cmt_bus_node #(
  parameter int BIT_CLK = 12
) (
  // Clock
  input wire logic clk_sys,
  // Bus
  input wire logic dut_tx,
  output logic     bus_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        node_tx = 1'b1;
  logic [48:0] sh;
  logic [31:0] rx_hdr;
  logic [15:0] rx_data;
  int          rx_cnt = 0;
  // Dominant low wins on the wire
  assign bus_rx = node_tx & dut_tx;
  // SOF, header, data, EOF and intermission, MSB first
  task send(input logic [31:0] h, input logic [15:0] d);
    logic [58:0] f;
    f = {1'b0, h, d, 10'h3ff};
    for (int i = 58; i >= 0; i--) begin
      node_tx <= f[i];
      repeat (BIT_CLK) @(posedge clk_sys);
    end
  endtask
  // Decodes frames started by the engine at mid-bit
  always begin
    @(negedge dut_tx);
    repeat (BIT_CLK / 2) @(posedge clk_sys);
    for (int i = 0; i < 49; i++) begin
      sh = {sh[47:0], bus_rx};
      repeat (BIT_CLK) @(posedge clk_sys);
    end
    {rx_hdr, rx_data} = sh[47:0];
    rx_cnt++;
  end
endmodule

// [tb_cmt_can_engine.sv]
/*
  Self-checking bench of cmt_can_engine: AHB-Lite tasks and bus frames.
  Assumes cmt_bus_node as the only other node on the wire.
*/
module tb_cmt_can_engine
  import cmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Prescaler field 0, segment fields 2 and 1
  // Twelve clocks a bit suffice while at most two replies can pend
  localparam int          BCLK    = int'(PRESC_ADD)
                                    * (1 + 2 + int'(SEGA_ADD) + 1 + int'(SEGB_ADD));
  localparam logic [31:0] TIM_VAL = 32'h0000_1200;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        bus_rx;
  logic        bus_tx;
  int          fail_count = 0;
  int          n_compared = 0;
  assign hready = hreadyout;
  always #5 clk_sys = ~clk_sys;
  cmt_can_engine #(.NUM_BUF(15), .OBJ_WAIT(2)) cmt_can_engine_i (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .bus_rx_pin(bus_rx), .bus_tx_pin(bus_tx));
  cmt_bus_node #(.BIT_CLK(BCLK)) cmt_bus_node_i (
    .clk_sys(clk_sys), .dut_tx(bus_tx), .bus_rx(bus_rx));
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [11:0] ba(input int n, input logic [3:0] o);
    return BUF_BASE + 12'(n * 16) + {8'h0, o};
  endfunction
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task bufset(input int n, input logic [31:0] h, input logic [15:0] d,
              input cmt_buf_state_type s);
    wr(ba(n, BUF_HDR), h);
    wr(ba(n, BUF_DATA), {16'h0, d});
    wr(ba(n, BUF_STATE), {29'h0, s});
  endtask
  // Waits for the engine's frame, then for its EOF and intermission
  task rxchk(input int n, input logic [31:0] h, input logic [15:0] d);
    int k;
    k = 0;
    while (cmt_bus_node_i.rx_cnt < n && k < 60 * BCLK) begin
      @(posedge clk_sys);
      k++;
    end
    cmp(32'(cmt_bus_node_i.rx_cnt), 32'(n));
    cmp(cmt_bus_node_i.rx_hdr, h);
    cmp({16'h0, cmt_bus_node_i.rx_data}, {16'h0, d});
    repeat (12 * BCLK) @(posedge clk_sys);
  endtask
  task end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cmp({31'h0, bus_tx}, 32'h1);
    chk(GMASK_OFS, GMASK_RST);
    chk(BMASK_OFS, BMASK_RST);
    chk(TIM_OFS, 32'h0);
    wr(12'h020, 32'hffff_ffff);
    chk(12'h020, 32'h0);
    chk(ba(15, BUF_HDR), 32'h0);
    wr(TIM_OFS, TIM_VAL);
    chk(TIM_OFS, TIM_VAL);
    wr(GMASK_OFS, 32'h1);
    wr(BMASK_OFS, 32'h1);
    wr(CTRL_OFS, 32'h1);
    $display("test registers done");
    bufset(0, 32'h1234_5670, 16'ha5a5, buf_reply_pending);
    bufset(6, 32'h1234_5670, 16'h5a5a, buf_reply_pending);
    cmt_bus_node_i.send(32'h1234_5671, 16'h0);
    chk(ba(6, BUF_STATE), {29'h0, buf_reply_single});
    rxchk(1, 32'h1234_5670, 16'ha5a5);
    rxchk(2, 32'h1234_5670, 16'h5a5a);
    chk(ba(0, BUF_STATE), {29'h0, buf_tx_idle});
    $display("test remote reply done");
    bufset(1, 32'h0abc_0010, 16'h0, buf_rx_empty);
    cmt_bus_node_i.send(32'h0abc_0010, 16'h1357);
    chk(ba(1, BUF_DATA), 32'h0000_1357);
    chk(ba(1, BUF_STATE), {29'h0, buf_rx_full});
    $display("test receive done");
    bufset(2, 32'h0246_8021, 16'h0, buf_tx_send);
    rxchk(3, 32'h0246_8021, 16'h0);
    chk(ba(2, BUF_STATE), {29'h0, buf_rx_empty});
    cmt_bus_node_i.send(32'h0246_8020, 16'h2468);
    chk(ba(2, BUF_DATA), 32'h0000_2468);
    $display("test remote request done");
    bufset(3, 32'h0777_0000, 16'h4444, buf_tx_idle);
    bufset(4, 32'h0777_0000, 16'h0, buf_rx_empty);
    bufset(5, 32'h0777_0000, 16'h0, buf_rx_empty);
    cmt_bus_node_i.send(32'h0777_0000, 16'h1111);
    chk(ba(4, BUF_DATA), 32'h0000_1111);
    chk(ba(5, BUF_STATE), {29'h0, buf_rx_empty});
    wr(ba(3, BUF_STATE), {29'h0, buf_tx_send});
    rxchk(4, 32'h0777_0000, 16'h4444);
    chk(ba(5, BUF_DATA), 32'h0000_4444);
    $display("test self copy done");
    wr(ba(4, BUF_STATE), {29'h0, buf_rx_empty});
    wr(ba(5, BUF_STATE), {29'h0, buf_rx_empty});
    cmt_bus_node_i.send(32'h0777_0000, 16'h2222);
    cmt_bus_node_i.send(32'h0999_0000, 16'h0);
    wr(ba(3, BUF_STATE), {29'h0, buf_tx_send});
    rxchk(5, 32'h0777_0000, 16'h4444);
    chk(ba(5, BUF_STATE), {29'h0, buf_rx_empty});
    chk(ba(4, BUF_DATA), 32'h0000_2222);
    $display("test no self copy done");
    end_sim();
  end
endmodule
